/* File: core/sepw_core.sv */
// write-protect, status byte and instruction gate of a serial eeprom
// assumes spi mode 0/3 pins sampled by sys_clk, which must run at least
// six times faster than the serial clock; the array engine outside
// takes cycleStart and answers with cycleDone when the cycle ends.
//
// Notes on behaviour
// - modify and status writes need a bit count that is a multiple of eight
// - chip select must rise between last bit edge and the next; else nothing
// - modify instructions need the enable latch set by the arm command
// - in deep power-down every program and erase command is ignored
// - end select 0 guards from the array top, 1 from the bottom
// - code 000 none, 001..110 64 KB doubling to 2 MB, 111 all 4 MB
// - erase accepted only when all three guard code bits are zero
// - lock bit set and write-protect pin low freezes bits, refuses status writes
// - pin high or lock bit clear lets status be written with latch set
// - writes into the guarded area refused, unguarded area accepted
// - status byte: lock, end, zero, guard code, latch, busy; msb first
// - status read repeats the status byte while chip select stays low
// - status write updates only lock, end select and guard code bits
// - arm sets latch; power-up and completed modify or disarm clear it
// - busy during internal cycle; only status read served; cleared at end
// - busy also stands while the power-up sequence runs
// - power-on reset and power-up timer block modify operations
// - as shipped end select and guard code are zero, array unguarded
// - power-on clears latch and cycle busy, sets busy for the power-up timer, keeps nonvolatile bits
// - deselect during hold abandons the instruction; latch, busy, power-down and nonvolatile bits survive
`timescale 1ns/1ps
`include "sepw_defines.svh"
module sepw_core #(
   parameter int PUW_CYCLES =
      (`POWERUP_WRITE_DELAY_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic powerOn, // supply crossed the reset threshold again
   input wire logic sckPin,
   input wire logic csNPin,
   input wire logic mosiPin,
   input wire logic wpNPin,
   input wire logic holdNPin,
   input wire logic cycleDone,
   output logic misoOut,
   output logic misoOeN,
   output logic cycleStart,
   output logic [7:0] cycleOpcode,
   output logic [23:0] cycleAddr,
   output logic [7:0] statusByte,
   output logic deepPowerDown
);
   sepw_pkg::sepw_core_s q;
   sepw_pkg::sepw_core_s d;

   logic [`PIN_COUNT-1:0] pinLevel;
   logic [`PIN_COUNT-1:0] pinRise;
   logic [`PIN_COUNT-1:0] pinFall;
   logic guardHit;
   logic aligned;
   logic [`LEN_W-1:0] nBytes;
   logic busy;
   logic pinGuard;
   logic [7:0] inByte;
   logic [`LEN_W-1:0] byteIdx;
   logic [7:0] curStatus;

   // status byte as seen on the bus and at the port
   function automatic logic [7:0] statusOf(input sepw_pkg::sepw_core_s s);
      logic [7:0] v;
      v = 8'h00;
      v[`SR_LOCK] = s.lockBit;
      v[`SR_END] = s.endSel;
      v[`SR_SPARE] = `SR_SPARE_VAL;
      v[`SR_GUARD_HI:`SR_GUARD_LO] = s.guardCode;
      v[`SR_WEL] = s.modify_enable_latch;
      v[`SR_BUSY] = s.cycleBusy | s.puBusy;
      return v;
   endfunction

   sepw_pin_sync #(
      .WIDTH(`PIN_COUNT),
      .IDLE(`PIN_IDLE)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pinIn({holdNPin, wpNPin, mosiPin, csNPin, sckPin}),
      .pinLevel(pinLevel),
      .pinRise(pinRise),
      .pinFall(pinFall)
   );

   // guard check looks at the address gathered for this instruction
   sepw_guard_map u_guard (
      .addr(q.addr),
      .endSel(q.endSel),
      .guardCode(q.guardCode),
      .guardHit(guardHit)
   );

   // next-state logic for the whole block
   always_comb begin
      d = q;
      d.start = 1'h0;
      aligned = (q.bitCnt[2:0] == 3'h0) && (q.bitCnt != '0);
      nBytes = q.bitCnt[`BIT_CNT_W-1:3];
      byteIdx = q.bitCnt[`BIT_CNT_W-1:3];
      busy = q.cycleBusy | q.puBusy;
      pinGuard = q.lockBit & ~pinLevel[`PIN_WP];
      inByte = {q.shiftIn[6:0], pinLevel[`PIN_MOSI]};
      // a function result cannot be bit-selected, so keep a copy
      curStatus = statusOf(q);

      // power-up timer; modify stays blocked until it expires
      if (q.puBusy) begin
         if (q.puCnt == `PU_CNT_W'(PUW_CYCLES - 1)) begin
            d.puBusy = 1'h0;
         end else begin
            d.puCnt = q.puCnt + `PU_CNT_W'(1);
         end
      end

      // end of the internal cycle frees the device and disarms it
      if (q.cycleBusy && cycleDone) begin
         d.cycleBusy = 1'h0;
         d.modify_enable_latch = 1'h0;
      end

      case (q.st)
         sepw_pkg::ST_IDLE: begin
            d.misoOeN = 1'h1;
            // selection is edge-sensitive: a low level alone is not enough
            if (pinFall[`PIN_CS]) begin
               d.st = sepw_pkg::ST_SHIFT;
               d.bitCnt = '0;
               d.shiftIn = 8'h00;
               d.opcode = 8'h00;
               d.addr = 24'h000000;
               d.srData = 8'h00;
            end
         end
         sepw_pkg::ST_SHIFT: begin
            if (pinRise[`PIN_CS]) begin
               // execution only at deselect, so a late raise counts an
               // extra edge and spoils the byte alignment
               d.st = sepw_pkg::ST_IDLE;
               d.misoOeN = 1'h1;
               if (!busy && aligned && q.deepPd) begin
                  // only the release command is heard in deep power-down
                  if (q.opcode == `OP_RELEASE && nBytes == `LEN_OPCODE) begin
                     d.deepPd = 1'h0;
                  end
               end else if (!busy && aligned) begin
                  case (q.opcode)
                     `OP_LATCH_ARM_CMD: begin
                        if (nBytes == `LEN_OPCODE) begin
                           d.modify_enable_latch = 1'h1;
                        end
                     end
                     `OP_WRDI: begin
                        if (nBytes == `LEN_OPCODE) begin
                           d.modify_enable_latch = 1'h0;
                        end
                     end
                     `OP_DPD: begin
                        if (nBytes == `LEN_OPCODE) begin
                           d.deepPd = 1'h1;
                        end
                     end
                     `OP_STATUS_WRITE_CMD: begin
                        // refused in pin guard mode or with latch clear
                        if (q.modify_enable_latch && !pinGuard &&
                            nBytes >= `LEN_STATUS_WRITE_CMD) begin
                           d.lockBit = q.srData[`SR_LOCK];
                           d.endSel = q.srData[`SR_END];
                           d.guardCode =
                              q.srData[`SR_GUARD_HI:`SR_GUARD_LO];
                           d.start = 1'h1;
                           d.cycleBusy = 1'h1;
                           d.startOp = q.opcode;
                           d.startAddr = q.addr;
                        end
                     end
                     `OP_PP, `OP_PW: begin
                        if (q.modify_enable_latch && !guardHit &&
                            nBytes >= `LEN_PROG) begin
                           d.start = 1'h1;
                           d.cycleBusy = 1'h1;
                           d.startOp = q.opcode;
                           d.startAddr = q.addr;
                        end
                     end
                     `OP_PE, `OP_SE, `OP_BE: begin
                        if (q.modify_enable_latch && q.guardCode == `GUARD_NONE &&
                            nBytes == `LEN_ADDR_CMD) begin
                           d.start = 1'h1;
                           d.cycleBusy = 1'h1;
                           d.startOp = q.opcode;
                           d.startAddr = q.addr;
                        end
                     end
                     `OP_CE: begin
                        if (q.modify_enable_latch && q.guardCode == `GUARD_NONE &&
                            nBytes == `LEN_OPCODE) begin
                           d.start = 1'h1;
                           d.cycleBusy = 1'h1;
                           d.startOp = q.opcode;
                           d.startAddr = 24'h000000;
                        end
                     end
                     default: begin
                        d.st = sepw_pkg::ST_IDLE;
                     end
                  endcase
               end
            end else if (!pinLevel[`PIN_HOLD] && !pinLevel[`PIN_SCK]) begin
               // pause: output floats, clock and data are don't care
               d.st = sepw_pkg::ST_HOLD;
               d.misoOeN = 1'h1;
            end else if (pinRise[`PIN_SCK]) begin
               d.shiftIn = inByte;
               // saturating count; a saturated count is never aligned
               if (q.bitCnt != '1) begin
                  d.bitCnt = q.bitCnt + `BIT_CNT_W'(1);
               end
               if (q.bitCnt[2:0] == 3'h7) begin
                  if (byteIdx == `BYTE_OPCODE) begin
                     d.opcode = inByte;
                  end else if (byteIdx <= `BYTE_ADDR_LAST) begin
                     d.addr = {q.addr[15:0], inByte};
                  end
                  if (byteIdx == `BYTE_SR_DATA) begin
                     d.srData = inByte;
                  end
               end
            end else if (pinFall[`PIN_SCK]) begin
               // shift status out on falling edges, byte after byte
               if (q.opcode == `OP_STATUS_READ_CMD && q.bitCnt >= `BIT_CNT_W'(8)) begin
                  d.misoQ = curStatus[3'h7 - q.bitCnt[2:0]];
                  d.misoOeN = 1'h0;
               end
            end
         end
         sepw_pkg::ST_HOLD: begin
            d.misoOeN = 1'h1;
            if (pinRise[`PIN_CS]) begin
               // abandon the instruction; latch and busy survive
               d.st = sepw_pkg::ST_IDLE;
               d.bitCnt = '0;
               d.opcode = 8'h00;
               d.addr = 24'h000000;
            end else if (pinLevel[`PIN_HOLD] && !pinLevel[`PIN_SCK]) begin
               d.st = sepw_pkg::ST_SHIFT;
               d.misoOeN = ~(q.opcode == `OP_STATUS_READ_CMD &&
                             q.bitCnt >= `BIT_CNT_W'(8));
            end
         end
         default: begin
            d.st = sepw_pkg::ST_IDLE;
         end
      endcase

      // a new supply ramp restarts the timer and wipes volatile bits only
      if (powerOn) begin
         d.st = sepw_pkg::ST_IDLE;
         d.modify_enable_latch = 1'h0;
         d.cycleBusy = 1'h0;
         d.puBusy = 1'h1;
         d.puCnt = '0;
         d.deepPd = 1'h0;
         d.start = 1'h0;
         d.misoOeN = 1'h1;
      end
   end

   // rst is the factory first start: guard bits come up unguarded
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q.st <= sepw_pkg::ST_IDLE;
         q.bitCnt <= '0;
         q.shiftIn <= 8'h00;
         q.opcode <= 8'h00;
         q.addr <= 24'h000000;
         q.srData <= 8'h00;
         q.lockBit <= 1'h0;
         q.endSel <= 1'h0;
         q.guardCode <= `GUARD_NONE;
         q.modify_enable_latch <= 1'h0;
         q.cycleBusy <= 1'h0;
         q.puBusy <= 1'h1;
         q.puCnt <= '0;
         q.deepPd <= 1'h0;
         q.misoQ <= 1'h0;
         q.misoOeN <= 1'h1;
         q.start <= 1'h0;
         q.startOp <= 8'h00;
         q.startAddr <= 24'h000000;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign misoOut = q.misoQ;
   assign misoOeN = q.misoOeN;
   assign cycleStart = q.start;
   assign cycleOpcode = q.startOp;
   assign cycleAddr = q.startAddr;
   assign statusByte = statusOf(q);
   assign deepPowerDown = q.deepPd;
endmodule

/* File: core/sepw_defines.svh */
// constants of the serial eeprom write-protect and status block
// assumes a 100 MHz system clock and an spi bus in mode 0 or 3
`ifndef SEPW_DEFINES_SVH
`define SEPW_DEFINES_SVH

`define SYS_CLK_NS 10
`define POWERUP_WRITE_DELAY_NS 1000000
`define PU_CNT_W 24
`define BIT_CNT_W 16
`define LEN_W 13

// status byte layout, msb shifted first
`define SR_LOCK 7
`define SR_END 6
`define SR_SPARE 5
`define SR_GUARD_HI 4
`define SR_GUARD_LO 2
`define SR_WEL 1
`define SR_BUSY 0
`define SR_SPARE_VAL 1'h0
`define GUARD_NONE 3'h0
`define GUARD_ALL 3'h7

// synchroniser lanes and their idle levels
`define PIN_SCK 0
`define PIN_CS 1
`define PIN_MOSI 2
`define PIN_WP 3
`define PIN_HOLD 4
`define PIN_COUNT 5
`define PIN_IDLE 5'h1A

// instruction codes
`define OP_STATUS_WRITE_CMD 8'h01
`define OP_PP 8'h02
`define OP_WRDI 8'h04
`define OP_STATUS_READ_CMD 8'h05
`define OP_LATCH_ARM_CMD 8'h06
`define OP_PW 8'h0A
`define OP_SE 8'h20
`define OP_RELEASE 8'hAB
`define OP_DPD 8'hB9
`define OP_CE 8'hC7
`define OP_BE 8'hD8
`define OP_PE 8'hDB

// instruction lengths and byte positions, in whole bytes
`define LEN_OPCODE 13'h1
`define LEN_STATUS_WRITE_CMD 13'h2
`define LEN_ADDR_CMD 13'h4
`define LEN_PROG 13'h5
`define BYTE_OPCODE 13'h0
`define BYTE_SR_DATA 13'h1
`define BYTE_ADDR_LAST 13'h3

// array geometry: 64 blocks of 64 KB
`define BLK_HI 21
`define BLK_LO 16
`define BLK_W 6
`endif

/* File: core/sepw_pkg.sv */
// types of the serial eeprom write-protect and status block
// assumes sepw_defines.svh is on the include path
`include "sepw_defines.svh"
package sepw_pkg;

   // gray along idle -> shift -> hold
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SHIFT = 2'h1,
      ST_HOLD = 2'h3
   } sepw_state_e;

   typedef struct packed {
      sepw_state_e st;
      logic [`BIT_CNT_W-1:0] bitCnt;
      logic [7:0] shiftIn;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] srData;
      logic lockBit;
      logic endSel;
      logic [2:0] guardCode;
      logic modify_enable_latch;
      logic cycleBusy;
      logic puBusy;
      logic [`PU_CNT_W-1:0] puCnt;
      logic deepPd;
      logic misoQ;
      logic misoOeN;
      logic start;
      logic [7:0] startOp;
      logic [23:0] startAddr;
   } sepw_core_s;

endpackage

/* File: core/sepw_pin_sync.sv */
// three-stage synchroniser with agreement filter for the spi pins
// assumes pins are asynchronous to sys_clk; outputs are on sys_clk
`timescale 1ns/1ps
`include "sepw_defines.svh"
module sepw_pin_sync #(
   parameter int WIDTH = `PIN_COUNT,
   parameter logic [WIDTH-1:0] IDLE = `PIN_IDLE
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinLevel,
   output logic [WIDTH-1:0] pinRise,
   output logic [WIDTH-1:0] pinFall
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
      logic [WIDTH-1:0] rise;
      logic [WIDTH-1:0] fall;
   } sepw_sync_s;

   sepw_sync_s q;
   sepw_sync_s d;

   // a level counts only once stages two and three agree
   always_comb begin
      d = q;
      d.s1 = pinIn;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.lvl[i] = q.s3[i];
         end
      end
      d.rise = d.lvl & ~q.lvl;
      d.fall = ~d.lvl & q.lvl;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '{IDLE, IDLE, IDLE, IDLE, '0, '0};
      end else begin
         q <= d;
      end
   end

   assign pinLevel = q.lvl;
   assign pinRise = q.rise;
   assign pinFall = q.fall;
endmodule

/* File: core/sepw_guard_map.sv */
// maps an array address onto the block-protect area
// assumes a 4 MB array of 64 blocks; purely combinational
`timescale 1ns/1ps
`include "sepw_defines.svh"
module sepw_guard_map (
   input wire logic [23:0] addr,
   input wire logic endSel,
   input wire logic [2:0] guardCode,
   output logic guardHit
);
   // protected span in blocks doubles per code step
   function automatic logic inGuard(input logic [`BLK_W-1:0] blk,
                                    input logic fromBottom,
                                    input logic [2:0] code);
      logic [`BLK_W:0] span;
      logic [`BLK_W:0] top;
      span = (`BLK_W+1)'(1) << (code - 3'h1);
      top = (`BLK_W+1)'(blk) + span;
      if (code == `GUARD_NONE) begin
         return 1'h0;
      end else if (code == `GUARD_ALL) begin
         return 1'h1;
      end else if (fromBottom) begin
         return (`BLK_W+1)'(blk) < span;
      end else begin
         return top[`BLK_W];
      end
   endfunction

   // top end: block + span overflows past the last block
   assign guardHit = inGuard(addr[`BLK_HI:`BLK_LO], endSel, guardCode);
endmodule

/* File: tb/sepw_core_chk.sv */
// assertions on the ports of the write-protect and status core
// assumes sepw_defines.svh on the include path; bound to sepw_core
`timescale 1ns/1ps
`include "sepw_defines.svh"
module sepw_core_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic powerOn,
   input wire logic csNPin,
   input wire logic wpNPin,
   input wire logic misoOeN,
   input wire logic cycleStart,
   input wire logic [7:0] cycleOpcode,
   input wire logic [23:0] cycleAddr,
   input wire logic [7:0] statusByte,
   input wire logic deepPowerDown
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // true when the block of the address lies in the guarded area
   function automatic logic inGuard(input logic [23:0] a, input logic e,
                                    input logic [2:0] c);
      logic [6:0] blk;
      logic [6:0] sz;
      blk = {1'b0, a[`BLK_HI:`BLK_LO]};
      sz = 7'h01 << (c - 3'h1);
      if (c == `GUARD_NONE) return 1'b0;
      if (c == `GUARD_ALL) return 1'b1;
      return e ? (blk < sz) : (blk >= 7'h40 - sz);
   endfunction

   // accepted cycles: latch armed, device idle before, busy after
   a_start_when_idle: assert property (cycleStart |->
      !$past(statusByte[`SR_BUSY]) && statusByte[`SR_BUSY])
      else $error("cycle started while busy or busy not raised");
   a_start_needs_latch: assert property (cycleStart |->
      statusByte[`SR_WEL]) else $error("cycle started with latch clear");
   a_erase_unguarded: assert property (cycleStart && cycleOpcode inside
      {`OP_SE, `OP_BE, `OP_PE, `OP_CE} |->
      statusByte[`SR_GUARD_HI:`SR_GUARD_LO] == `GUARD_NONE)
      else $error("erase accepted with a guard code set");
   a_prog_outside_guard: assert property (cycleStart &&
      cycleOpcode inside {`OP_PP, `OP_PW} |-> !inGuard(cycleAddr,
      statusByte[`SR_END], statusByte[`SR_GUARD_HI:`SR_GUARD_LO]))
      else $error("program accepted inside the guarded area");
   a_pin_lock_holds: assert property (cycleStart &&
      cycleOpcode == `OP_STATUS_WRITE_CMD |->
      !($past(statusByte[`SR_LOCK]) && !$past(wpNPin, 6)))
      else $error("status write accepted under pin lock");
   a_nv_only_by_write: assert property (
      $changed(statusByte[`SR_LOCK:`SR_GUARD_LO]) |->
      cycleStart && cycleOpcode == `OP_STATUS_WRITE_CMD)
      else $error("nonvolatile status bits changed without status write");
   a_spare_reads_zero: assert property (
      statusByte[`SR_SPARE] == `SR_SPARE_VAL)
      else $error("spare status bit not zero");
   a_sleep_no_cycle: assert property (
      deepPowerDown && $past(deepPowerDown) |-> !cycleStart)
      else $error("cycle started in deep power-down");
   a_power_on_clears: assert property (powerOn |=>
      !statusByte[`SR_WEL] && statusByte[`SR_BUSY])
      else $error("power-on did not clear latch or raise busy");
   a_read_ends_deselect: assert property ($rose(csNPin) |->
      ##[1:8] misoOeN) else $error("output still driven after deselect");

   c_status_write: cover property (cycleStart && cycleOpcode == `OP_STATUS_WRITE_CMD);
   c_status_read: cover property ($fell(misoOeN));
   c_sleep_left: cover property ($fell(deepPowerDown));
endmodule

bind sepw_core sepw_core_chk chk_u (.sys_clk, .rst, .powerOn, .csNPin,
   .wpNPin, .misoOeN, .cycleStart, .cycleOpcode, .cycleAddr, .statusByte,
   .deepPowerDown);

/* File: tb/sepw_host.sv */
// spi bus master model driving the serial pins in mode 0
// assumes a pull-up on the data output line and sys_clk at 100 MHz
`timescale 1ns/1ps
module sepw_host (
   input wire logic sys_clk,
   input wire logic misoOut,
   input wire logic misoOeN,
   output logic sckPin,
   output logic csNPin,
   output logic mosiPin
);
   logic misoLine;

   // released output floats to the pull-up level, never the last bit
   assign misoLine = misoOeN ? 1'b1 : misoOut;

   initial begin
      sckPin = 1'b0;
      csNPin = 1'b1;
      mosiPin = 1'b0;
   end

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   // send the low n bits msb first; serial clock idles low between frames
   task automatic xfer(input logic [39:0] d, input int n,
                       output logic [15:0] rx);
      rx = 16'h0000;
      csNPin = 1'b0;
      tick(8);
      for (int i = 0; i < n; i++) begin
         mosiPin = d[n-1-i];
         tick(8);
         sckPin = 1'b1;
         rx = {rx[14:0], misoLine};
         tick(8);
         sckPin = 1'b0;
      end
      tick(4);
      csNPin = 1'b1;
      mosiPin = ~mosiPin;
      tick(16);
   endtask
endmodule

/* File: tb/sepw_core_tb.sv */
// self-checking bench of the write-protect and status core
// assumes the host model drives the pins and a 300-cycle array engine
`timescale 1ns/1ps
module sepw_core_tb;
   typedef struct {
      bit wp;
      logic [39:0] c;
      int n;
      logic [8:0] e;
      bit s;
   } sepw_row_s;
   logic sys_clk, rst, powerOn, wpNPin, cycleDone, started;
   logic sckPin, csNPin, mosiPin, misoOut, misoOeN, cycleStart;
   logic deepPowerDown;
   logic [7:0] cycleOpcode, statusByte;
   logic [23:0] cycleAddr;
   logic [15:0] rx;
   int badCount = 0;
   int cmpCount = 0;
   // wp, instruction, bits, {power-down, status} after, cycle expected
   sepw_row_s rows [34] = '{
      '{1,40'h06,8,9'h002,0}, '{1,40'h04,8,9'h000,0},
      '{1,40'h03,7,9'h000,0}, '{1,40'h0200000000,40,9'h000,0},
      '{1,40'h06,8,9'h002,0}, '{1,40'h013B,16,9'h018,1},
      '{1,40'h06,8,9'h01A,0}, '{1,40'h023F000000,40,9'h01A,0},
      '{1,40'h021F000000,40,9'h018,1}, '{1,40'h06,8,9'h01A,0},
      '{1,40'h20000000,32,9'h01A,0}, '{1,40'h0158,16,9'h058,1},
      '{1,40'h06,8,9'h05A,0}, '{1,40'h0200000000,40,9'h05A,0},
      '{1,40'h0220000000,40,9'h058,1}, '{1,40'h06,8,9'h05A,0},
      '{1,40'h011C,16,9'h01C,1}, '{1,40'h06,8,9'h01E,0},
      '{1,40'h0220000000,40,9'h01E,0}, '{1,40'h03000,17,9'h01E,0},
      '{1,40'h0180,16,9'h080,1}, '{1,40'h06,8,9'h082,0},
      '{1,40'h20010000,32,9'h080,1}, '{0,40'h06,8,9'h082,0},
      '{0,40'h0100,16,9'h082,0}, '{1,40'h0100,16,9'h000,1},
      '{1,40'h06,8,9'h002,0}, '{1,40'hB9,8,9'h102,0},
      '{1,40'h0200000000,40,9'h102,0}, '{1,40'hAB,8,9'h002,0},
      '{1,40'h0200000000,40,9'h000,1}, '{1,40'h06,8,9'h002,0},
      '{1,40'h019C,16,9'h09C,1}, '{1,40'h06,8,9'h09E,0}};

   sepw_core #(.PUW_CYCLES(20)) dut_u (.sys_clk(sys_clk), .rst(rst),
      .powerOn(powerOn), .sckPin(sckPin), .csNPin(csNPin),
      .mosiPin(mosiPin), .wpNPin(wpNPin), .holdNPin(1'b1),
      .cycleDone(cycleDone), .misoOut(misoOut), .misoOeN(misoOeN),
      .cycleStart(cycleStart), .cycleOpcode(cycleOpcode),
      .cycleAddr(cycleAddr), .statusByte(statusByte),
      .deepPowerDown(deepPowerDown));
   sepw_host host_u (.sys_clk(sys_clk), .misoOut(misoOut),
      .misoOeN(misoOeN), .sckPin(sckPin), .csNPin(csNPin),
      .mosiPin(mosiPin));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // array engine: slow enough that a short instruction fits inside
   always begin
      @(posedge sys_clk);
      if (cycleStart === 1'b1) begin
         started = 1'b1;
         repeat (300) @(posedge sys_clk);
         #1 cycleDone = 1'b1;
         @(posedge sys_clk);
         #1 cycleDone = 1'b0;
      end
   end

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [15:0] got,
                      input logic [15:0] exp);
      cmpCount++;
      if (got !== exp) begin
         badCount++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask

   // poll busy under a bound instead of a worst-case wait
   task automatic waitIdle();
      for (int i = 0; i < 400 && statusByte[0] !== 1'b0; i++) tick(1);
   endtask

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      // rows take about 14k cycles at most; leave over four times that
      #600000;
      badCount++;
      $display("unexpected watchdog: expected end, seen hang");
      summarize();
   end

   initial begin
      rst = 1'b1;
      powerOn = 1'b0;
      wpNPin = 1'b1;
      cycleDone = 1'b0;
      started = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 rst = 1'b0;
      tick(2);
      chk("status", {8'h00, statusByte}, 16'h0001);
      tick(25);
      chk("status", {8'h00, statusByte}, 16'h0000);
      $display("reset test done");
      // ordinary instruction rows; wp changes long before acceptance
      foreach (rows[i]) begin
         wpNPin = rows[i].wp;
         started = 1'b0;
         host_u.xfer(rows[i].c, rows[i].n, rx);
         waitIdle();
         chk("status", {7'h00, deepPowerDown, statusByte},
             {7'h00, rows[i].e});
         chk("cycle", {15'h0000, started}, {15'h0000, rows[i].s});
         $display("row %0d test done", i);
      end
      // status read loops the byte msb first while selected
      host_u.xfer(40'h050000, 24, rx);
      chk("status read", rx, 16'h9E9E);
      $display("status read test done");
      // power cycle keeps nonvolatile bits, drops latch, busy again
      powerOn = 1'b1;
      tick(1);
      powerOn = 1'b0;
      tick(1);
      chk("power-on", {8'h00, statusByte}, 16'h009D);
      tick(25);
      chk("power-on", {8'h00, statusByte}, 16'h009C);
      $display("power-on test done");
      // disarm sent during the cycle is ignored; latch drops at the end
      host_u.xfer(40'h06, 8, rx);
      host_u.xfer(40'h0100, 16, rx);
      host_u.xfer(40'h04, 8, rx);
      chk("busy", {8'h00, statusByte}, 16'h0003);
      chk("opcode", {8'h00, cycleOpcode}, 16'h0001);
      waitIdle();
      chk("busy", {8'h00, statusByte}, 16'h0000);
      $display("busy test done");
      summarize();
   end
endmodule
